/* dv/counter_host_port_asserts.sv */
/*
  pin level checker for the counter chip host data port.
  assumes it is bound onto counter_host_port, one clock domain.
*/
`timescale 1ns/1ps
module counter_host_port_asserts
  import counter_port_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic cmd_sel,
  input wire logic [15:0] data_in,
  input wire logic [15:0] data_out,
  input wire logic data_oe_n,
  input wire logic [NUM_COUNTERS-1:0] count_in,
  input wire logic [NUM_COUNTERS-1:0] gate_in,
  input wire logic [NUM_COUNTERS-1:0] out_pin,
  input wire logic [NUM_COUNTERS-1:0] out_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  AST_CS_IDLE: assert property (cs_n [*5] |-> data_oe_n)
    else $error("bus driven while deselected");
  AST_RD_IDLE: assert property (rd_n [*5] |-> data_oe_n)
    else $error("bus driven without a read");
  AST_READ_ANSWER: assert property ($fell(rd_n) && !cs_n && wr_n ##1 (!rd_n && !cs_n) [*4] |-> !data_oe_n)
    else $error("no prefetched answer to a read");
  AST_READ_HOLD: assert property (!data_oe_n && $past(data_oe_n) == 1'b0 && !cmd_sel |-> $stable(data_out))
    else $error("data port value moved during a read");
  AST_OE_RELEASE: assert property ($rose(rd_n) && !data_oe_n |-> ##[1:5] data_oe_n)
    else $error("bus not released after read");
  AST_STATUS_UPPER: assert property ($fell(data_oe_n) && cmd_sel |-> data_out[15:6] == 10'h000)
    else $error("status upper bits not zero");
  AST_STATUS_PIN: assert property ($fell(data_oe_n) && cmd_sel && $stable(out_pin) |-> data_out[5:1] == out_pin)
    else $error("status bits differ from out pins");
  AST_HIGHZ_DRIVE: assert property ((out_oe_n & ~out_pin) == 5'h00)
    else $error("low output left undriven");
  // writes act a few clocks after the strobe, hence eight quiet cycles
  AST_OUT_QUIET: assert property (($stable(count_in) && wr_n) [*8] |-> $stable(out_pin))
    else $error("out pin changed with no count or write");
endmodule
bind counter_host_port counter_host_port_asserts u_counter_host_port_asserts (
  .clk(clk), .reset_n(reset_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
  .cmd_sel(cmd_sel), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
  .count_in(count_in), .gate_in(gate_in), .out_pin(out_pin), .out_oe_n(out_oe_n)
);

/* dv/host_bus.sv */
/*
  host processor model on the parallel bus: command, data write, read.
  assumes the bench calls one task at a time.
*/
`timescale 1ns/1ps
module host_bus (
  input wire logic clk,
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic cmd_sel,
  output logic [15:0] data_in,
  input wire logic [15:0] data_out,
  input wire logic data_oe_n
);
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    cmd_sel = 1'b0;
    data_in = 16'hA5C3;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // only one strobe is ever low
  task automatic wr(input logic cd, input logic [15:0] d, input logic sel_n);
    cyc(1);
    cs_n = sel_n;
    cmd_sel = cd;
    data_in = d;
    cyc(2);
    wr_n = 1'b0;
    cyc(5);
    wr_n = 1'b1;
    cyc(4);
    data_in = ~d; // released bus must not look like the old value
    cs_n = 1'b1;
    cyc(4); // write recovery
  endtask
  task automatic rd(input logic cd, output logic [15:0] d);
    int n;
    cyc(1);
    cs_n = 1'b0;
    cmd_sel = cd;
    cyc(2);
    rd_n = 1'b0;
    n = 0;
    while (data_oe_n !== 1'b0 && n < 12) begin
      cyc(1);
      n++;
    end
    d = (data_oe_n === 1'b0) ? data_out : 16'hXXXX;
    cyc(3);
    rd_n = 1'b1;
    cyc(4);
    cs_n = 1'b1;
    cyc(4);
  endtask
endmodule

/* dv/tb_top.sv */
/*
  self-checking bench for counter_host_port against an integer model.
  assumes the checker binds itself and host_bus drives the bus.
*/
`timescale 1ns/1ps
module tb_top;
  logic clk;
  logic reset_n;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic cmd_sel;
  logic [15:0] data_in;
  logic [15:0] data_out;
  logic data_oe_n;
  logic [4:0] count_in;
  logic [4:0] gate_in;
  logic [4:0] out_pin;
  logic [4:0] out_oe_n;
  int n_fail;
  int checks_done;
  int cycles;
  int seed;
  int rld[6];
  int cap[6];
  int cnt1;
  int q[$];
  logic wide;
  logic [15:0] v;
  logic [2:0] oc_tab[3] = '{3'h1, 3'h2, 3'h5};

  counter_host_port u_counter_host_port (
    .clk(clk), .reset_n(reset_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .cmd_sel(cmd_sel), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
    .count_in(count_in), .gate_in(gate_in), .out_pin(out_pin), .out_oe_n(out_oe_n)
  );
  host_bus u_host_bus (
    .clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .cmd_sel(cmd_sel),
    .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n)
  );

  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // upper bits held high; random filler below them on a byte bus
  task automatic cmd(input logic [7:0] code);
    logic [4:0] r;
    r = 5'($random(seed));
    u_host_bus.wr(1'b1, {wide ? 8'hFF : {3'b111, r}, code}, 1'b0);
  endtask
  task automatic wreg(input logic [15:0] d);
    logic [4:0] r;
    r = 5'($random(seed));
    if (wide)
      u_host_bus.wr(1'b0, d, 1'b0);
    else begin
      u_host_bus.wr(1'b0, {3'b111, r, d[7:0]}, 1'b0);
      u_host_bus.wr(1'b0, {3'b111, r, d[15:8]}, 1'b0);
    end
  endtask
  task automatic rchk(input string what, input logic cd, input logic [15:0] exp);
    logic [15:0] d;
    u_host_bus.rd(cd, d);
    chk(what, d, exp);
  endtask
  task automatic pulse();
    count_in[0] = 1'b1;
    u_host_bus.cyc(4);
    count_in[0] = 1'b0;
    u_host_bus.cyc(6);
    cnt1 = (cnt1 == 1) ? rld[1] : cnt1 - 1; // reload instead of reaching zero
  endtask

  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    count_in = 5'h00;
    gate_in = 5'h00;
    wide = 1'b0;
    n_fail = 0;
    checks_done = 0;
    cycles = 0;
    cnt1 = 0;
    seed = 32'h98F9;
    repeat (16) @(posedge clk);
    #2;
    reset_n = 1'b1;
    rchk("reset status", 1'b1, 16'h0001);
    v = 16'($random(seed));
    cmd(8'h09);
    wreg(v);
    cmd(8'h09);
    rchk("low byte", 1'b0, {8'h00, v[7:0]});
    rchk("byte ptr", 1'b1, 16'h0000);
    rchk("high byte", 1'b0, {8'h00, v[15:8]});
    cmd(8'h17);
    wreg(16'h2000);
    wide = 1'b1;
    rchk("ptr after pair", 1'b1, 16'h0001);
    for (int g = 1; g <= 5; g++) begin
      cmd(8'(g));
      for (int e = 0; e < 3; e++) begin
        v = 16'($random(seed));
        if (e == 0)
          v = v & 16'hFF98;
        q.push_back(int'(v));
        wreg(v);
      end
    end
    for (int g = 1; g <= 5; g++) begin
      cmd(8'(g));
      for (int e = 0; e < 3; e++) begin
        v = 16'(q.pop_front());
        if (e == 1)
          rld[g] = v;
        if (e == 2)
          cap[g] = v;
        rchk("group reg", 1'b0, v);
      end
    end
    cmd(8'h19);
    for (int g = 1; g <= 5; g++)
      rchk("hold cycle", 1'b0, 16'(cap[g]));
    cmd(8'h01);
    cmd(8'hA1);
    wreg(16'h0000);
    rchk("write prefetch", 1'b0, 16'(rld[1]));
    cmd(8'h11);
    rchk("save", 1'b0, 16'h0000);
    cmd(8'h09);
    u_host_bus.wr(1'b0, 16'h5A5A, 1'b1);
    u_host_bus.wr(1'b1, 16'hFF0A, 1'b1);
    rchk("deselected", 1'b0, 16'(rld[1]));
    cmd(8'h09);
    wreg(16'h0003);
    rld[1] = 3;
    cmd(8'h41);
    cnt1 = 3;
    cmd(8'h21);
    pulse();
    pulse();
    cmd(8'hA1);
    cmd(8'h11);
    rchk("mid count", 1'b0, 16'(cnt1));
    pulse();
    chk("tc out", {11'h000, out_pin}, 16'h0001);
    rchk("tc status", 1'b1, 16'h0003);
    cmd(8'hA1);
    cmd(8'h11);
    rchk("reloaded", 1'b0, 16'(cnt1));
    // gate edge capture on counter four leaves the prefetch stale
    cmd(8'h04);
    wreg(16'h0020);
    cmd(8'h48);
    cmd(8'h14);
    gate_in[3] = 1'b1;
    u_host_bus.cyc(6);
    gate_in[3] = 1'b0;
    u_host_bus.cyc(4);
    rchk("stale prefetch", 1'b0, 16'(cap[4]));
    cmd(8'h14);
    rchk("gate capture", 1'b0, 16'(rld[4]));
    cmd(8'hC1);
    cmd(8'h07);
    wreg(16'h0003);
    cmd(8'h17);
    wreg(16'h2004);
    foreach (oc_tab[i]) begin
      cmd(8'h01);
      wreg({13'h0000, oc_tab[i]});
      chk("compare out", {15'h0000, out_pin[0]}, {15'h0000, oc_tab[i] != 3'h5});
    end
    cmd(8'h03);
    wreg(16'h0004);
    chk("highz out", {14'h0000, out_pin[2], out_oe_n[2]}, 16'h0003);
    rchk("status", 1'b1, 16'h0009);
    cmd(8'h1F);
    rchk("data status", 1'b0, 16'h0009);
    rchk("data status 2", 1'b0, 16'h0009);
    cmd(8'h17);
    wreg(16'h6004);
    cmd(8'h0A);
    wreg(16'h1111);
    v = 16'($random(seed));
    wreg(v);
    rchk("fixed ptr", 1'b0, v);
    rchk("fixed ptr 2", 1'b0, v);
    tally_and_finish();
  end
endmodule

/* hw/counter_host_port.sv */
/*
  host data port of a five channel 16-bit counter chip: control/data port
  decode, auto advancing pointer with read prefetch latch, status register,
  counter groups with reload and capture, compare on the first two.
  assumes host strobes are slow enough to be seen through two-flop
  synchronisers and that setup/hold around the strobes spans several clocks.
*/
`timescale 1ns/1ps
module counter_host_port
  import counter_port_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic cmd_sel,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic data_oe_n,
  input wire logic [NUM_COUNTERS-1:0] count_in,
  input wire logic [NUM_COUNTERS-1:0] gate_in,
  output logic [NUM_COUNTERS-1:0] out_pin,
  output logic [NUM_COUNTERS-1:0] out_oe_n
);
  localparam int SYNC_W = 4 + 16 + 2 * NUM_COUNTERS;

  logic [SYNC_W-1:0] sync1_reg, sync2_reg;
  logic rd_prev_reg, wr_prev_reg;
  logic [NUM_COUNTERS-1:0] count_prev_reg, gate_prev_reg;
  logic s_cs_n, s_rd_n, s_wr_n, s_cmd;
  logic [15:0] s_data;
  logic [NUM_COUNTERS-1:0] s_count, s_gate;

  // every pin passes two flops; the edge detectors read only stage two
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg <= {SYNC_W{1'b1}};
      sync2_reg <= {SYNC_W{1'b1}};
      rd_prev_reg <= 1'b1;
      wr_prev_reg <= 1'b1;
      count_prev_reg <= '1;
      gate_prev_reg <= '1;
    end else begin
      sync1_reg <= {cs_n, rd_n, wr_n, cmd_sel, data_in, count_in, gate_in};
      sync2_reg <= sync1_reg;
      rd_prev_reg <= s_rd_n;
      wr_prev_reg <= s_wr_n;
      count_prev_reg <= s_count;
      gate_prev_reg <= s_gate;
    end
  end

  assign {s_cs_n, s_rd_n, s_wr_n, s_cmd, s_data, s_count, s_gate} = sync2_reg;

  logic selected, rd_start, rd_done, wr_done;
  assign selected = !s_cs_n;
  assign rd_start = selected && rd_prev_reg && !s_rd_n && s_wr_n;
  assign rd_done = selected && !rd_prev_reg && s_rd_n;
  assign wr_done = selected && !wr_prev_reg && s_wr_n;

  // port and counter state
  logic [2:0] group_reg, group_next;
  logic [1:0] elem_reg, elem_next;
  logic byte_ptr_reg, byte_ptr_next;
  logic [7:0] low_byte_reg, low_byte_next;
  logic [15:0] prefetch_reg, prefetch_next;
  logic refresh_reg, refresh_next;
  logic [15:0] data_out_reg, data_out_next;
  logic drive_reg, drive_next;
  logic [15:0] master_reg, master_next;
  logic [15:0] reload_value_reg [NUM_COUNTERS];
  logic [15:0] reload_value_next [NUM_COUNTERS];
  logic [15:0] capture_or_alt_reload_reg [NUM_COUNTERS];
  logic [15:0] capture_or_alt_reload_next [NUM_COUNTERS];
  logic [15:0] counter_config_reg [NUM_COUNTERS];
  logic [15:0] counter_config_next [NUM_COUNTERS];
  logic [15:0] count_reg [NUM_COUNTERS];
  logic [15:0] count_next [NUM_COUNTERS];
  logic [15:0] compare_value_reg [NUM_COMPARE];
  logic [15:0] compare_value_next [NUM_COMPARE];
  logic [NUM_COUNTERS-1:0] armed_reg, armed_next;
  logic [NUM_COUNTERS-1:0] terminal_count_event_reg, terminal_count_event_next;

  logic [NUM_COUNTERS-1:0] out_level;
  logic [7:0] output_status;
  logic [2:0] gidx;
  logic [15:0] sel_value;
  logic bus16, auto_off, on_status;

  assign bus16 = master_reg[MM_BUS_WIDTH_BIT];
  assign auto_off = master_reg[MM_AUTO_SEQ_DISABLE_BIT];
  assign gidx = group_reg - 3'h1;
  assign on_status = (group_reg == GROUP_CONTROL) && (elem_reg == ELEM_STATUS);

  // output level after polarity, before the pin buffer
  genvar gi;
  generate
    for (gi = 0; gi < NUM_COUNTERS; gi++) begin : g_out
      logic [2:0] out_ctrl;
      logic source;
      assign out_ctrl = counter_config_reg[gi][CFG_OUT_CTRL_LSB +: 3];
      if (gi < NUM_COMPARE) begin : g_cmp
        // compare holds while equal, i.e. until the next count step
        assign source = master_reg[MM_COMPARE1_BIT + gi] ?
                        (count_reg[gi] == compare_value_reg[gi]) :
                        terminal_count_event_reg[gi];
      end else begin : g_tc
        assign source = terminal_count_event_reg[gi];
      end
      // polarity bit set inverts: grounded is active-high, high-z active-low
      assign out_level[gi] = source ^ out_ctrl[CFG_POLARITY_BIT];
      // high-z option only pulls low when asserted, otherwise releases
      assign out_oe_n[gi] = (out_ctrl == OUT_CTRL_HIGH_Z) ? out_level[gi] : 1'b0;
      assign out_pin[gi] = out_level[gi];
    end
  endgenerate

  always_comb begin
    output_status = 8'h00;
    output_status[STATUS_BYTE_PTR_BIT] = byte_ptr_reg;
    output_status[STATUS_OUT_LSB +: NUM_COUNTERS] = out_level;
  end

  // register selected by the pointer, fed into the prefetch latch
  always_comb begin
    sel_value = RESET_WORD;
    if (group_reg == GROUP_CONTROL) begin
      case (elem_reg)
        ELEM_COMPARE1: sel_value = compare_value_reg[0];
        ELEM_COMPARE2: sel_value = compare_value_reg[1];
        ELEM_MASTER: sel_value = master_reg;
        default: sel_value = {8'h00, output_status};
      endcase
    end else if (group_reg >= GROUP_FIRST && group_reg <= GROUP_LAST) begin
      case (elem_reg)
        ELEM_CONFIG: sel_value = counter_config_reg[gidx];
        ELEM_RELOAD: sel_value = reload_value_reg[gidx];
        default: sel_value = capture_or_alt_reload_reg[gidx];
      endcase
    end
  end

  // next pointer in element, capture or control cycle
  function automatic logic [4:0] advance(input logic [2:0] g, input logic [1:0] e);
    logic [2:0] ng;
    logic [1:0] ne;
    ng = g;
    ne = e;
    if (g == GROUP_CONTROL) begin
      if (e != ELEM_STATUS) begin
        ne = (e == ELEM_WRAP) ? ELEM_CONFIG : e + 2'h1;
      end
    end else if (e == ELEM_CAPTURE_CYCLE) begin
      ng = (g == GROUP_LAST) ? GROUP_FIRST : g + 3'h1;
    end else begin
      ne = (e == ELEM_WRAP) ? ELEM_CONFIG : e + 2'h1;
      if (e == ELEM_WRAP) begin
        ng = (g == GROUP_LAST) ? GROUP_FIRST : g + 3'h1;
      end
    end
    return {ng, ne};
  endfunction

  always_comb begin
    logic [15:0] word;
    logic [4:0] sel;
    logic [2:0] op;
    logic access_done, word_done;
    word = RESET_WORD;
    sel = s_data[4:0];
    op = s_data[7:5];
    access_done = 1'b0;
    word_done = 1'b0;
    group_next = group_reg;
    elem_next = elem_reg;
    byte_ptr_next = byte_ptr_reg;
    low_byte_next = low_byte_reg;
    prefetch_next = prefetch_reg;
    refresh_next = 1'b0;
    data_out_next = data_out_reg;
    drive_next = drive_reg && selected && !s_rd_n;
    master_next = master_reg;
    reload_value_next = reload_value_reg;
    capture_or_alt_reload_next = capture_or_alt_reload_reg;
    counter_config_next = counter_config_reg;
    count_next = count_reg;
    compare_value_next = compare_value_reg;
    armed_next = armed_reg;
    terminal_count_event_next = terminal_count_event_reg;

    // latch refilled one clock after the pointer settles
    if (refresh_reg) begin
      prefetch_next = sel_value;
    end

    // counting: reload at what would have been zero
    for (int i = 0; i < NUM_COUNTERS; i++) begin
      if (s_gate[i] && !gate_prev_reg[i] && counter_config_reg[i][CFG_GATE_SAVE_BIT]) begin
        capture_or_alt_reload_next[i] = count_reg[i]; // no prefetch refresh here
      end
      if (s_count[i] && !count_prev_reg[i] && armed_reg[i]) begin
        terminal_count_event_next[i] = (count_reg[i] == COUNT_ONE);
        if (count_reg[i] == COUNT_ONE) begin
          count_next[i] = counter_config_reg[i][CFG_RELOAD_SRC_BIT] ?
                          capture_or_alt_reload_reg[i] : reload_value_reg[i];
        end else begin
          count_next[i] = count_reg[i] - COUNT_ONE;
        end
      end
    end

    if (rd_start) begin
      drive_next = 1'b1;
      if (s_cmd || on_status) begin
        data_out_next = {8'h00, output_status}; // live, not prefetched
      end else if (bus16) begin
        data_out_next = prefetch_reg;
      end else begin
        data_out_next = {8'h00, byte_ptr_reg ? prefetch_reg[7:0] : prefetch_reg[15:8]};
      end
    end

    if (wr_done && s_cmd) begin
      // command on low byte; upper bits are the host's concern
      if (op == OP_POINTER_LOAD) begin
        if ((sel[2:0] >= GROUP_FIRST && sel[2:0] <= GROUP_LAST) || sel[2:0] == GROUP_CONTROL) begin
          group_next = sel[2:0];
          elem_next = sel[4:3];
          byte_ptr_next = 1'b1;
          refresh_next = 1'b1;
        end
      end else begin
        for (int i = 0; i < NUM_COUNTERS; i++) begin
          if (sel[i]) begin
            case (op)
              OP_ARM: armed_next[i] = 1'b1;
              OP_LOAD: count_next[i] = counter_config_reg[i][CFG_RELOAD_SRC_BIT] ?
                                       capture_or_alt_reload_reg[i] : reload_value_reg[i];
              OP_LOAD_ARM: begin
                count_next[i] = counter_config_reg[i][CFG_RELOAD_SRC_BIT] ?
                                capture_or_alt_reload_reg[i] : reload_value_reg[i];
                armed_next[i] = 1'b1;
              end
              OP_DISARM_SAVE: begin
                armed_next[i] = 1'b0;
                capture_or_alt_reload_next[i] = count_reg[i];
              end
              OP_SAVE: capture_or_alt_reload_next[i] = count_reg[i];
              OP_DISARM: armed_next[i] = 1'b0;
              default: armed_next[i] = armed_reg[i];
            endcase
          end
        end
      end
    end

    if (wr_done && !s_cmd) begin
      access_done = 1'b1;
      if (bus16) begin
        word_done = 1'b1;
        word = s_data;
      end else if (byte_ptr_reg) begin
        low_byte_next = s_data[7:0];
      end else begin
        word_done = 1'b1;
        word = {s_data[7:0], low_byte_reg}; // low byte first
      end
      if (word_done) begin
        if (group_reg == GROUP_CONTROL) begin
          case (elem_reg)
            ELEM_COMPARE1: compare_value_next[0] = word;
            ELEM_COMPARE2: compare_value_next[1] = word;
            ELEM_MASTER: master_next = word;
            default: master_next = master_reg; // status is read-only
          endcase
        end else if (group_reg >= GROUP_FIRST && group_reg <= GROUP_LAST) begin
          case (elem_reg)
            ELEM_CONFIG: counter_config_next[gidx] = word;
            ELEM_RELOAD: reload_value_next[gidx] = word;
            default: capture_or_alt_reload_next[gidx] = word;
          endcase
        end
      end
    end

    if (rd_done && !s_cmd) begin
      access_done = 1'b1;
      word_done = bus16 || !byte_ptr_reg;
    end

    if (access_done) begin
      byte_ptr_next = bus16 ? 1'b1 : !byte_ptr_reg;
      if (word_done) begin
        // any completed data write refills, even with no advance
        refresh_next = 1'b1;
        if (!auto_off) begin
          {group_next, elem_next} = advance(group_reg, elem_reg);
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      group_reg <= RESET_GROUP;
      elem_reg <= RESET_ELEM;
      byte_ptr_reg <= 1'b1;
      low_byte_reg <= 8'h00;
      prefetch_reg <= RESET_WORD;
      refresh_reg <= 1'b0;
      data_out_reg <= RESET_WORD;
      drive_reg <= 1'b0;
      master_reg <= RESET_WORD;
      armed_reg <= '0;
      terminal_count_event_reg <= '0;
      for (int i = 0; i < NUM_COUNTERS; i++) begin
        reload_value_reg[i] <= RESET_WORD;
        capture_or_alt_reload_reg[i] <= RESET_WORD;
        counter_config_reg[i] <= RESET_WORD;
        count_reg[i] <= RESET_WORD;
      end
      for (int i = 0; i < NUM_COMPARE; i++) begin
        compare_value_reg[i] <= RESET_WORD;
      end
    end else begin
      group_reg <= group_next;
      elem_reg <= elem_next;
      byte_ptr_reg <= byte_ptr_next;
      low_byte_reg <= low_byte_next;
      prefetch_reg <= prefetch_next;
      refresh_reg <= refresh_next;
      data_out_reg <= data_out_next;
      drive_reg <= drive_next;
      master_reg <= master_next;
      armed_reg <= armed_next;
      terminal_count_event_reg <= terminal_count_event_next;
      reload_value_reg <= reload_value_next;
      capture_or_alt_reload_reg <= capture_or_alt_reload_next;
      counter_config_reg <= counter_config_next;
      count_reg <= count_next;
      compare_value_reg <= compare_value_next;
    end
  end

  assign data_out = data_out_reg;
  // bus released on the third clock after the read strobe or select goes away
  assign data_oe_n = !drive_reg;
endmodule

/* shared/counter_port_pkg.sv */
/*
  constants for the counter chip host data port: pointer codes, register
  fields, command opcodes, status layout and reset values.
  assumes a single 40 MHz clock domain and five counter groups.
*/
package counter_port_pkg;
  localparam int NUM_COUNTERS = 5;
  localparam int NUM_COMPARE = 2;
  localparam int CLK_PERIOD_NS = 25;

  // pointer fields: group in low three bits, element in the next two
  localparam logic [2:0] GROUP_FIRST = 3'h1;
  localparam logic [2:0] GROUP_LAST = 3'h5;
  localparam logic [2:0] GROUP_CONTROL = 3'h7;
  localparam logic [1:0] ELEM_CONFIG = 2'h0;
  localparam logic [1:0] ELEM_RELOAD = 2'h1;
  localparam logic [1:0] ELEM_CAPTURE = 2'h2;
  localparam logic [1:0] ELEM_CAPTURE_CYCLE = 2'h3;
  localparam logic [1:0] ELEM_COMPARE1 = 2'h0;
  localparam logic [1:0] ELEM_COMPARE2 = 2'h1;
  localparam logic [1:0] ELEM_MASTER = 2'h2;
  localparam logic [1:0] ELEM_STATUS = 2'h3;
  localparam logic [1:0] ELEM_WRAP = 2'h2;

  // command byte: opcode in top three bits, counter select in low five
  localparam logic [2:0] OP_POINTER_LOAD = 3'h0;
  localparam logic [2:0] OP_ARM = 3'h1;
  localparam logic [2:0] OP_LOAD = 3'h2;
  localparam logic [2:0] OP_LOAD_ARM = 3'h3;
  localparam logic [2:0] OP_DISARM_SAVE = 3'h4;
  localparam logic [2:0] OP_SAVE = 3'h5;
  localparam logic [2:0] OP_DISARM = 3'h6;

  // master mode bit positions
  localparam int MM_COMPARE1_BIT = 2;
  localparam int MM_BUS_WIDTH_BIT = 13;
  localparam int MM_AUTO_SEQ_DISABLE_BIT = 14;

  // counter config fields
  localparam int CFG_OUT_CTRL_LSB = 0;
  localparam int CFG_POLARITY_BIT = 2;
  localparam int CFG_GATE_SAVE_BIT = 5;
  localparam int CFG_RELOAD_SRC_BIT = 6;
  localparam logic [2:0] OUT_CTRL_GROUNDED = 3'h0;
  localparam logic [2:0] OUT_CTRL_HIGH_Z = 3'h4;

  // status layout
  localparam int STATUS_BYTE_PTR_BIT = 0;
  localparam int STATUS_OUT_LSB = 1;

  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [2:0] RESET_GROUP = GROUP_CONTROL;
  localparam logic [1:0] RESET_ELEM = ELEM_STATUS;
endpackage
